// [pkt_mem_model.sv]
// Purpose: Packet memory answering descriptor reads
// Assumes: One request at a time, held until ack
// Notes:   Data inverted after ack so stale reads show
`timescale 1ns/1ps
module pkt_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    input  wire logic [3:0]  dly,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata
);
    logic [3:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt       <= 4'h0;
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0;
        end else if (mem_ack) begin
            mem_ack   <= 1'b0;
            cnt       <= 4'h0;
            mem_rdata <= ~mem_rdata;
        end else if (mem_req && cnt == dly) begin
            mem_ack   <= 1'b1;
            mem_rdata <= {mem_addr ^ 16'h5a5a, mem_addr};
        end else if (mem_req) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// [tb_usb_ep_regs.sv]
// Purpose: Self-checking bench for usb_ep_regs
// Assumes: clk_en held high
// Notes:   Endpoint registers mirrored in ep_m
`timescale 1ns/1ps
module tb_usb_ep_regs;
    logic        pclk, presetn, psel, penable, pwrite, usb_bus_reset, frame_start, txn_start;
    logic        txn_end, txn_ok, pready, pslverr, mem_req, mem_ack, rx_buf_sel, desc_valid;
    logic        frame_pulse_out, dplus_pullup_en, xfer_done_irq, e;
    logic [1:0]  txn_kind;
    logic [2:0]  txn_ep, txn_end_ep;
    logic [3:0]  dly;
    logic [7:0]  paddr;
    logic [15:0] mem_addr, buf_start, buf_size, base, a, ep_m [8];
    logic [31:0] pwdata, prdata, mem_rdata, q, seed;
    int          n_mismatch, n_tests;
    usb_ep_regs usb_ep_regs_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .usb_bus_reset(usb_bus_reset), .frame_start(frame_start),
        .txn_start(txn_start), .txn_ep(txn_ep), .txn_end(txn_end), .txn_end_ep(txn_end_ep),
        .txn_kind(txn_kind), .txn_ok(txn_ok), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .buf_start(buf_start), .buf_size(buf_size),
        .rx_buf_sel(rx_buf_sel), .desc_valid(desc_valid), .frame_pulse_out(frame_pulse_out),
        .dplus_pullup_en(dplus_pullup_en), .xfer_done_irq(xfer_done_irq));
    pkt_mem_model pkt_mem_model_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .dly(dly), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    always #50 pclk = ~pclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Done w0 clears; toggle and state w1 flip
    function automatic logic [15:0] f_wr(input logic [15:0] o, input logic [15:0] w);
        return {o[15] & w[15], o[14] ^ w[14], o[13:12] ^ w[13:12], 1'b0, w[10:8], o[7] & w[7], 3'h0, w[3:0]};
    endfunction
    function automatic logic [15:0] f_ev(input logic [15:0] o, input logic [1:0] k, input logic ok);
        if (ok && k == 2'h2) o[7] = 1'b1;
        if (ok && k <= 2'h1) begin
            o[15] = 1'b1;
            o[14] = (k == 2'h1 && o[10:9] == 2'h1) ? 1'b1 : ~o[14];
            if (o[10:9] != 2'h2) o[13:12] = 2'h2;
        end
        return o;
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_hi(input logic m);
        for (int n = 0; n < 40; n++) begin
            @(posedge pclk);
            if ((m ? desc_valid : pready) === 1'b1) return;
        end
        n_mismatch++;
        results();
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_hi(1'b0);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_ep(input logic [2:0] i);
        apb(1'b0, {3'h0, i, 2'h0}, 32'h0);
        chk(q, {16'h0, ep_m[i]});
    endtask
    task automatic wep(input logic [2:0] i, input logic [15:0] w);
        apb(1'b1, {3'h0, i, 2'h0}, {~w, w});
        ep_m[i] = f_wr(ep_m[i], w);
    endtask
    task automatic ev(input logic [2:0] i, input logic [1:0] k, input logic ok);
        @(posedge pclk);
        txn_end    <= 1'b1;
        txn_end_ep <= i;
        txn_kind   <= k;
        txn_ok     <= ok;
        @(posedge pclk);
        txn_end <= 1'b0;
        ep_m[i] = f_ev(ep_m[i], k, ok);
        rd_ep(i);
    endtask
    task automatic fetch(input logic [2:0] i);
        seed = lfsr(seed);
        @(posedge pclk);
        dly       <= seed[3:0];
        txn_start <= 1'b1;
        txn_ep    <= i;
        @(posedge pclk);
        txn_start <= 1'b0;
        wait_hi(1'b1);
        a = base + {10'h0, i, 3'h0};
        chk({buf_size, buf_start}, {a ^ 16'h5a5a, a});
        chk(rx_buf_sel, ep_m[i][14]);
    endtask
    task automatic pulse(input logic exp);
        @(posedge pclk);
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        @(negedge pclk);
        chk(frame_pulse_out, exp);
    endtask
    task automatic rst_chk(input logic w);
        for (int i = 0; i < 8; i++) begin
            ep_m[i] = ep_m[i] & 16'h8080;
            rd_ep(i[2:0]);
            if (w) wep(i[2:0], 16'hff8f);
        end
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, usb_bus_reset, frame_start, txn_start} = 8'h0;
        {txn_end, txn_ok, txn_kind, txn_ep, txn_end_ep, dly, paddr, pwdata} = 54'h0;
        {n_mismatch, n_tests, base} = 0;
        seed = 32'h61ea864b;
        for (int i = 0; i < 8; i++) ep_m[i] = 16'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd_ep(i[2:0]);
        apb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, 8'h50, 32'hffffffff);
        apb(1'b0, 8'h50, 32'h0);
        chk(q, 32'hfff8);
        seed = lfsr(seed);
        base = seed[15:0] & 16'hfff8;
        apb(1'b1, 8'h50, seed);
        apb(1'b0, 8'h50, 32'h0);
        chk(q, {16'h0, base});
        apb(1'b1, 8'h44, 32'h2);
        wep(3'h0, 16'hf280);
        wep(3'h1, 16'hb081);
        wep(3'h2, 16'hb482);
        wep(3'h3, 16'h8083);
        ev(3'h1, 2'h0, 1'b0);
        ev(3'h1, 2'h0, 1'b1);
        ev(3'h0, 2'h1, 1'b1);
        ev(3'h2, 2'h0, 1'b1);
        ev(3'h3, 2'h2, 1'b1);
        repeat (2) @(negedge pclk);
        chk(xfer_done_irq, 1'b1);
        for (int i = 0; i < 4; i++) fetch(i[2:0]);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            if (seed[19])
                ev(seed[18:16], {seed[20], 1'b0}, seed[21]);
            else
                wep(seed[18:16], seed[15:0]);
            rd_ep(seed[18:16]);
        end
        apb(1'b1, 8'h60, 32'h3);
        repeat (2) @(negedge pclk);
        chk(dplus_pullup_en, 1'b0);
        pulse(1'b1);
        apb(1'b1, 8'h60, 32'h0);
        pulse(1'b0);
        chk(dplus_pullup_en, 1'b1);
        apb(1'b1, 8'h44, 32'h1);
        apb(1'b1, 8'h44, 32'h0);
        rst_chk(1'b1);
        repeat (2) @(negedge pclk);
        chk(xfer_done_irq, 1'b0);
        @(posedge pclk);
        usb_bus_reset <= 1'b1;
        repeat (2) @(posedge pclk);
        usb_bus_reset <= 1'b0;
        rst_chk(1'b0);
        results();
    end
endmodule

// [usb_ep_pkg.sv]
// Purpose: Shared constants for the endpoint register block
// Assumes: 32-bit APB data, byte addresses in an 8-bit window
// Notes:   Endpoint register n sits at 4*n
package usb_ep_pkg;
    localparam int          NUM_EP           = 8;
    localparam logic [7:0]  OFF_EP_BASE      = 8'h00;
    localparam logic [7:0]  OFF_EP_LAST      = 8'h1c;
    localparam logic [7:0]  OFF_MAIN_CTRL    = 8'h44;
    localparam logic [7:0]  OFF_BUF_TABLE    = 8'h50;
    localparam logic [7:0]  OFF_FRAME_PULSE  = 8'h60;

    // Endpoint register fields
    localparam int          EP_RX_DONE_BIT   = 15;
    localparam int          EP_RX_TOGGLE_BIT = 14;
    localparam int          EP_RX_STATE_HI   = 13;
    localparam int          EP_RX_STATE_LO   = 12;
    localparam int          EP_TYPE_HI       = 10;
    localparam int          EP_TYPE_LO       = 9;
    localparam int          EP_KIND_BIT      = 8;
    localparam int          EP_TX_DONE_BIT   = 7;
    localparam int          EP_NUMBER_HI     = 3;
    localparam logic [15:0] EP_RESET         = 16'h0000;

    // Buffer table base: bits 15:3 stored, 2:0 read zero
    localparam int          BUF_TABLE_LO     = 3;
    localparam logic [15:0] BUF_TABLE_RESET  = 16'h0000;

    // Frame pulse / pull-up control
    localparam int          FRAME_OUT_EN_BIT = 0;
    localparam int          PULLUP_DIS_BIT   = 1;
    localparam logic [1:0]  FRAME_CTRL_RESET = 2'h0;

    // Main control
    localparam int          FORCE_RESET_BIT  = 0;
    localparam int          IRQ_EN_BIT       = 1;
    localparam logic [1:0]  MAIN_CTRL_RESET  = 2'h0;

    // Descriptor entry: 8 bytes per endpoint
    localparam int          DESC_SHIFT       = 3;

    typedef enum logic [1:0] {
        EP_BULK,
        EP_CONTROL,
        EP_ISO,
        EP_INTERRUPT
    } ep_type_e;

    typedef enum logic [1:0] {
        RX_DISABLED,
        RX_STALL,
        RX_NAK,
        RX_VALID
    } rx_state_e;

    typedef enum logic [1:0] {
        TXN_OUT,
        TXN_SETUP,
        TXN_IN,
        TXN_NONE
    } txn_kind_e;
endpackage

// [usb_ep_regs.sv]
// Purpose: Endpoint control/status, buffer table base and frame/pull-up control over APB
// Assumes: Link logic and packet memory on pclk; bus reset already synchronised
// Notes:   One APB wait state on every access
//
// Function
// - Table base kept in bits 15:3; table aligned to eight bytes.
// - A transaction start while no fetch is waiting fetches the addressed endpoint's table entry from packet memory.
// - Base register bits 2:0 always read zero.
// - Control bit 1 set disables the D+ pull-up, clear enables it.
// - Control bit 0 set passes the frame pulse to the pins.
// - Eight endpoints, each with its own control/status register.
// - Bus reset or force reset clears endpoint fields except both done flags.
// - Good OUT/SETUP sets receive done; writing zero clears, one keeps.
// - Done flag with interrupt enable raises the interrupt output.
// - NAK or STALL ended transactions never set receive done.
// - Non-iso receive toggle inverts after a correct acknowledged packet.
// - SETUP on a control endpoint sets the receive toggle to one.
// - Receive toggle picks the buffer of a double-buffered endpoint.
// - Iso endpoints invert the toggle at packet end with no handshake.
// - Software write of one inverts the receive toggle, zero keeps.
// - Bits 13:12 report the endpoint receive state.
// - Endpoint registers span offsets 0x00 to 0x1c.
// - Good OUT/SETUP moves a non-iso receive state to NAK.
// - Iso receive state is left alone after a transaction.
// - Good IN sets transmit done; writing zero clears it.
`timescale 1ns/1ps
module usb_ep_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        usb_bus_reset,
    input  wire logic        frame_start,
    input  wire logic        txn_start,
    input  wire logic [2:0]  txn_ep,
    input  wire logic        txn_end,
    input  wire logic [2:0]  txn_end_ep,
    input  wire logic [1:0]  txn_kind,
    input  wire logic        txn_ok,
    output logic             mem_req,
    output logic      [15:0] mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic      [15:0] buf_start,
    output logic      [15:0] buf_size,
    output logic             rx_buf_sel,
    output logic             desc_valid,
    output logic             frame_pulse_out,
    output logic             dplus_pullup_en,
    output logic             xfer_done_irq
);
    localparam int N = usb_ep_pkg::NUM_EP;

    typedef enum logic [1:0] {
        F_IDLE,
        F_WAIT,
        F_DONE
    } fetch_e;

    // APB state
    logic        pready_r,  pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r,  prdata_nxt;

    // Endpoint fields
    logic [N-1:0] rx_done_r,   rx_done_nxt;
    logic [N-1:0] tx_done_r,   tx_done_nxt;
    logic [N-1:0] rx_toggle_r, rx_toggle_nxt;
    logic [1:0]   rx_state_r   [N],
                  rx_state_nxt [N];
    logic [1:0]   ep_type_r    [N],
                  ep_type_nxt  [N];
    logic [N-1:0] ep_kind_r,   ep_kind_nxt;
    logic [3:0]   ep_num_r     [N],
                  ep_num_nxt   [N];

    // Global registers
    logic [15:3] buf_base_r,  buf_base_nxt;
    logic [1:0]  frame_ctrl_r, frame_ctrl_nxt;
    logic [1:0]  main_ctrl_r,  main_ctrl_nxt;

    // Descriptor fetch
    fetch_e      fetch_r, fetch_nxt;
    logic [2:0]  fetch_ep_r, fetch_ep_nxt;
    logic        mem_req_r, mem_req_nxt;
    logic [15:0] mem_addr_r, mem_addr_nxt;
    logic [15:0] buf_start_r, buf_start_nxt;
    logic [15:0] buf_size_r, buf_size_nxt;
    logic        rx_buf_sel_r, rx_buf_sel_nxt;
    logic        desc_valid_r, desc_valid_nxt;

    // Pin-facing outputs
    logic        frame_pulse_r, frame_pulse_nxt;
    logic        pullup_en_r,   pullup_en_nxt;
    logic        irq_r,         irq_nxt;

    logic        setup_ph;
    logic        wr_fire;
    logic        ep_hit;
    logic [2:0]  ep_idx;
    logic        ep_soft_reset;

    assign setup_ph      = psel && penable && !pready_r;
    assign wr_fire       = psel && penable && pready_r && pwrite;
    assign ep_hit        = (paddr <= usb_ep_pkg::OFF_EP_LAST) && (paddr[1:0] == 2'h0);
    assign ep_idx        = paddr[4:2];
    assign ep_soft_reset = usb_bus_reset || main_ctrl_r[usb_ep_pkg::FORCE_RESET_BIT];

    // APB slave: answer one cycle into the access phase
    always_comb begin
        logic [15:0] rd;
        logic        hit;
        rd          = 16'h0000;
        hit         = 1'b1;
        pready_nxt  = setup_ph;
        pslverr_nxt = 1'b0;
        prdata_nxt  = prdata_r;
        if (ep_hit) begin
            rd[usb_ep_pkg::EP_RX_DONE_BIT]   = rx_done_r[ep_idx];
            rd[usb_ep_pkg::EP_RX_TOGGLE_BIT] = rx_toggle_r[ep_idx];
            rd[usb_ep_pkg::EP_RX_STATE_HI:usb_ep_pkg::EP_RX_STATE_LO] = rx_state_r[ep_idx];
            rd[usb_ep_pkg::EP_TYPE_HI:usb_ep_pkg::EP_TYPE_LO] = ep_type_r[ep_idx];
            rd[usb_ep_pkg::EP_KIND_BIT]      = ep_kind_r[ep_idx];
            rd[usb_ep_pkg::EP_TX_DONE_BIT]   = tx_done_r[ep_idx];
            rd[usb_ep_pkg::EP_NUMBER_HI:0]   = ep_num_r[ep_idx];
        end else if (paddr == usb_ep_pkg::OFF_BUF_TABLE) begin
            rd = {buf_base_r, 3'h0};
        end else if (paddr == usb_ep_pkg::OFF_FRAME_PULSE) begin
            rd = {14'h0000, frame_ctrl_r};
        end else if (paddr == usb_ep_pkg::OFF_MAIN_CTRL) begin
            rd = {14'h0000, main_ctrl_r};
        end else begin
            hit = 1'b0;
        end
        if (setup_ph) begin
            prdata_nxt  = pwrite ? 32'h0000_0000 : {16'h0000, rd};
            pslverr_nxt = !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // Global registers
    always_comb begin
        buf_base_nxt   = buf_base_r;
        frame_ctrl_nxt = frame_ctrl_r;
        main_ctrl_nxt  = main_ctrl_r;
        if (wr_fire) begin
            if (paddr == usb_ep_pkg::OFF_BUF_TABLE) begin
                buf_base_nxt = pwdata[15:usb_ep_pkg::BUF_TABLE_LO];
            end
            if (paddr == usb_ep_pkg::OFF_FRAME_PULSE) begin
                frame_ctrl_nxt = pwdata[1:0];
            end
            if (paddr == usb_ep_pkg::OFF_MAIN_CTRL) begin
                main_ctrl_nxt = pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_base_r   <= usb_ep_pkg::BUF_TABLE_RESET[15:3];
            frame_ctrl_r <= usb_ep_pkg::FRAME_CTRL_RESET;
            main_ctrl_r  <= usb_ep_pkg::MAIN_CTRL_RESET;
        end else if (clk_en) begin
            buf_base_r   <= buf_base_nxt;
            frame_ctrl_r <= frame_ctrl_nxt;
            main_ctrl_r  <= main_ctrl_nxt;
        end
    end

    // Endpoint registers: write and link event merge in one cycle
    always_comb begin
        logic wr_ep;
        logic ev_rx;
        logic ev_in;
        logic is_iso;
        logic is_ctrl;
        wr_ep   = 1'b0;
        ev_rx   = 1'b0;
        ev_in   = 1'b0;
        is_iso  = 1'b0;
        is_ctrl = 1'b0;
        rx_done_nxt   = rx_done_r;
        tx_done_nxt   = tx_done_r;
        rx_toggle_nxt = rx_toggle_r;
        ep_kind_nxt   = ep_kind_r;
        for (int i = 0; i < N; i++) begin
            rx_state_nxt[i] = rx_state_r[i];
            ep_type_nxt[i]  = ep_type_r[i];
            ep_num_nxt[i]   = ep_num_r[i];
            wr_ep   = wr_fire && ep_hit && (ep_idx == i[2:0]);
            ev_rx   = txn_end && txn_ok && (txn_end_ep == i[2:0]) &&
                      (txn_kind == usb_ep_pkg::TXN_OUT || txn_kind == usb_ep_pkg::TXN_SETUP);
            ev_in   = txn_end && txn_ok && (txn_end_ep == i[2:0]) && (txn_kind == usb_ep_pkg::TXN_IN);
            is_iso  = ep_type_r[i] == usb_ep_pkg::EP_ISO;
            is_ctrl = ep_type_r[i] == usb_ep_pkg::EP_CONTROL;
            if (wr_ep) begin
                // Zero clears; a set below wins
                if (!pwdata[usb_ep_pkg::EP_RX_DONE_BIT]) begin
                    rx_done_nxt[i] = 1'b0;
                end
                if (!pwdata[usb_ep_pkg::EP_TX_DONE_BIT]) begin
                    tx_done_nxt[i] = 1'b0;
                end
                rx_toggle_nxt[i] = rx_toggle_r[i] ^ pwdata[usb_ep_pkg::EP_RX_TOGGLE_BIT];
                rx_state_nxt[i]  = rx_state_r[i] ^
                                   pwdata[usb_ep_pkg::EP_RX_STATE_HI:usb_ep_pkg::EP_RX_STATE_LO];
                ep_type_nxt[i]   = pwdata[usb_ep_pkg::EP_TYPE_HI:usb_ep_pkg::EP_TYPE_LO];
                ep_kind_nxt[i]   = pwdata[usb_ep_pkg::EP_KIND_BIT];
                ep_num_nxt[i]    = pwdata[usb_ep_pkg::EP_NUMBER_HI:0];
            end
            if (ev_rx) begin
                rx_done_nxt[i] = 1'b1;
                if (is_iso) begin
                    // No handshake on iso, flip at packet end
                    rx_toggle_nxt[i] = !rx_toggle_nxt[i];
                end else begin
                    if (is_ctrl && txn_kind == usb_ep_pkg::TXN_SETUP) begin
                        // Cleared on SETUP, then advanced by its ACK
                        rx_toggle_nxt[i] = 1'b1;
                    end else begin
                        rx_toggle_nxt[i] = !rx_toggle_nxt[i];
                    end
                    rx_state_nxt[i] = usb_ep_pkg::RX_NAK;
                end
                // Iso state left as software set it
            end
            if (ev_in) begin
                tx_done_nxt[i] = 1'b1;
            end
            if (ep_soft_reset) begin
                // Done flags survive so pending work is not lost
                rx_toggle_nxt[i] = 1'b0;
                rx_state_nxt[i]  = usb_ep_pkg::EP_RESET[13:12];
                ep_type_nxt[i]   = usb_ep_pkg::EP_RESET[10:9];
                ep_kind_nxt[i]   = 1'b0;
                ep_num_nxt[i]    = usb_ep_pkg::EP_RESET[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_done_r   <= '0;
            tx_done_r   <= '0;
            rx_toggle_r <= '0;
            ep_kind_r   <= '0;
            for (int i = 0; i < N; i++) begin
                rx_state_r[i] <= usb_ep_pkg::EP_RESET[13:12];
                ep_type_r[i]  <= usb_ep_pkg::EP_RESET[10:9];
                ep_num_r[i]   <= usb_ep_pkg::EP_RESET[3:0];
            end
        end else if (clk_en) begin
            rx_done_r   <= rx_done_nxt;
            tx_done_r   <= tx_done_nxt;
            rx_toggle_r <= rx_toggle_nxt;
            ep_kind_r   <= ep_kind_nxt;
            for (int i = 0; i < N; i++) begin
                rx_state_r[i] <= rx_state_nxt[i];
                ep_type_r[i]  <= ep_type_nxt[i];
                ep_num_r[i]   <= ep_num_nxt[i];
            end
        end
    end

    // Descriptor fetch; a start during a fetch is dropped
    always_comb begin
        fetch_nxt      = fetch_r;
        fetch_ep_nxt   = fetch_ep_r;
        mem_req_nxt    = mem_req_r;
        mem_addr_nxt   = mem_addr_r;
        buf_start_nxt  = buf_start_r;
        buf_size_nxt   = buf_size_r;
        rx_buf_sel_nxt = rx_buf_sel_r;
        desc_valid_nxt = desc_valid_r;
        case (fetch_r)
            F_IDLE, F_DONE: begin
                if (txn_start) begin
                    fetch_nxt      = F_WAIT;
                    fetch_ep_nxt   = txn_ep;
                    mem_req_nxt    = 1'b1;
                    mem_addr_nxt   = {buf_base_r, 3'h0} + {10'h000, txn_ep, 3'h0};
                    desc_valid_nxt = 1'b0;
                end
            end
            F_WAIT: begin
                if (mem_ack) begin
                    fetch_nxt      = F_DONE;
                    mem_req_nxt    = 1'b0;
                    buf_start_nxt  = mem_rdata[15:0];
                    buf_size_nxt   = mem_rdata[31:16];
                    rx_buf_sel_nxt = rx_toggle_r[fetch_ep_r];
                    desc_valid_nxt = 1'b1;
                end
            end
            default: begin
                fetch_nxt   = F_IDLE;
                mem_req_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_r      <= F_IDLE;
            fetch_ep_r   <= 3'h0;
            mem_req_r    <= 1'b0;
            mem_addr_r   <= 16'h0000;
            buf_start_r  <= 16'h0000;
            buf_size_r   <= 16'h0000;
            rx_buf_sel_r <= 1'b0;
            desc_valid_r <= 1'b0;
        end else if (clk_en) begin
            fetch_r      <= fetch_nxt;
            fetch_ep_r   <= fetch_ep_nxt;
            mem_req_r    <= mem_req_nxt;
            mem_addr_r   <= mem_addr_nxt;
            buf_start_r  <= buf_start_nxt;
            buf_size_r   <= buf_size_nxt;
            rx_buf_sel_r <= rx_buf_sel_nxt;
            desc_valid_r <= desc_valid_nxt;
        end
    end

    // Pin-facing outputs, one register stage
    always_comb begin
        frame_pulse_nxt = frame_start && frame_ctrl_r[usb_ep_pkg::FRAME_OUT_EN_BIT];
        pullup_en_nxt   = !frame_ctrl_r[usb_ep_pkg::PULLUP_DIS_BIT];
        irq_nxt         = main_ctrl_r[usb_ep_pkg::IRQ_EN_BIT] && (|(rx_done_r | tx_done_r));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_pulse_r <= 1'b0;
            pullup_en_r   <= 1'b0;
            irq_r         <= 1'b0;
        end else if (clk_en) begin
            frame_pulse_r <= frame_pulse_nxt;
            pullup_en_r   <= pullup_en_nxt;
            irq_r         <= irq_nxt;
        end
    end

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign mem_req         = mem_req_r;
    assign mem_addr        = mem_addr_r;
    assign buf_start       = buf_start_r;
    assign buf_size        = buf_size_r;
    assign rx_buf_sel      = rx_buf_sel_r;
    assign desc_valid      = desc_valid_r;
    assign frame_pulse_out = frame_pulse_r;
    assign dplus_pullup_en = pullup_en_r;
    assign xfer_done_irq   = irq_r;
endmodule

// [usb_ep_regs_checker.sv]
// Purpose: Port-level assertions for usb_ep_regs
// Assumes: clk_en held high
// Notes:   Written control bits shadowed locally
`timescale 1ns/1ps
module usb_ep_regs_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        frame_start,
    input wire logic        txn_start,
    input wire logic [2:0]  txn_ep,
    input wire logic        mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic [15:0] buf_start,
    input wire logic [15:0] buf_size,
    input wire logic        desc_valid,
    input wire logic        frame_pulse_out,
    input wire logic        dplus_pullup_en,
    input wire logic        xfer_done_irq
);
    logic [15:0] base_r;
    logic [1:0]  live_r;
    logic        fr_r, pu_r, irq_r, wr_ok;
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_r <= 16'h0;
            live_r <= 2'h0;
            fr_r   <= 1'b0;
            pu_r   <= 1'b0;
            irq_r  <= 1'b0;
        end else begin
            if (live_r != 2'h2) live_r <= live_r + 2'h1;
            if (wr_ok && paddr == usb_ep_pkg::OFF_BUF_TABLE) base_r <= {pwdata[15:3], 3'h0};
            if (wr_ok && paddr == usb_ep_pkg::OFF_FRAME_PULSE) {pu_r, fr_r} <= pwdata[1:0];
            if (wr_ok && paddr == usb_ep_pkg::OFF_MAIN_CTRL) irq_r <= pwdata[1];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    a_frame_pulse: assert property (live_r == 2'h2 |-> frame_pulse_out == ($past(frame_start) && $past(fr_r)))
        else $error("frame pulse wrong");
    a_pullup_ctrl: assert property (live_r == 2'h2 |-> dplus_pullup_en == !$past(pu_r))
        else $error("pull-up enable wrong");
    a_fetch_start: assert property (txn_start && !mem_req |=> mem_req && !desc_valid
        && mem_addr == base_r + {10'h0, $past(txn_ep), 3'h0}) else $error("fetch address wrong");
    a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("request dropped early");
    a_ack_load: assert property (mem_req && mem_ack |=> !mem_req && desc_valid
        && {buf_size, buf_start} == $past(mem_rdata)) else $error("descriptor not loaded");
    a_irq_gate: assert property (xfer_done_irq |-> $past(irq_r)) else $error("irq without enable");
    c_err: cover property (pslverr);
    c_fetch: cover property (mem_req && mem_ack);
    c_frame: cover property (frame_pulse_out);
    c_irq: cover property (xfer_done_irq);
endmodule
bind usb_ep_regs usb_ep_regs_checker usb_ep_regs_checker_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_start(frame_start),
    .txn_start(txn_start), .txn_ep(txn_ep), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .buf_start(buf_start), .buf_size(buf_size),
    .desc_valid(desc_valid), .frame_pulse_out(frame_pulse_out),
    .dplus_pullup_en(dplus_pullup_en), .xfer_done_irq(xfer_done_irq));
